// ---- timer0_pkg.sv ----
// Register map, field layout, encodings and divider constants of the capture/compare timer
package timer0_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_COUNTER = 8'h00;
	localparam logic [7:0] OFF_CCA     = 8'h04;
	localparam logic [7:0] OFF_CCB     = 8'h08;
	localparam logic [7:0] OFF_PRM     = 8'h0C;
	localparam logic [7:0] OFF_MODE    = 8'h10;
	localparam logic [7:0] OFF_CRC     = 8'h14;
	localparam logic [7:0] OFF_TOC     = 8'h18;
	localparam logic [7:0] OFF_FLAGS   = 8'h1C;

	// Prescaler mode register fields
	localparam int PRM_CKS_LSB = 0;
	localparam int PRM_ES0_LSB = 4;
	localparam int PRM_ES1_LSB = 6;

	// Capture/compare control register fields
	localparam int CRC_A_CAP = 0;
	localparam int CRC_A_INV = 1;
	localparam int CRC_B_CAP = 2;

	// Output control register fields
	localparam int TOC_OE     = 0;
	localparam int TOC_TOGGLE = 1;

	// Flag register fields
	localparam int FLAG_A = 0;
	localparam int FLAG_B = 1;

	// Reset values
	localparam logic [7:0]  PRM_RST  = 8'h00;
	localparam logic [2:0]  CRC_RST  = 3'h0;
	localparam logic [1:0]  TOC_RST  = 2'h0;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

	// Prescaler: 6-bit free-running divider, masks for /4, /8 and /64
	localparam int         PRESC_W    = 6;
	localparam logic [5:0] DIV4_MASK  = 6'h03;
	localparam logic [5:0] DIV8_MASK  = 6'h07;
	localparam logic [5:0] DIV64_MASK = 6'h3F;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_STOP        = 2'b00,
		MODE_FREE        = 2'b01,
		MODE_RESTART     = 2'b10,
		MODE_CLEAR_MATCH = 2'b11
	} run_mode_t;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BAD  = 2'b10,
		EDGE_BOTH = 2'b11
	} edge_sel_t;

	typedef enum logic [1:0] {
		CKS_FULL  = 2'b00,
		CKS_DIV4  = 2'b01,
		CKS_DIV64 = 2'b10,
		CKS_EXT   = 2'b11
	} clk_sel_t;

endpackage

// ---- edge_filter.sv ----
// Pin synchroniser and two-sample noise filter giving rise and fall pulses
`timescale 1ns/1ps
module edge_filter (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// Sampling strobe and raw pin
	input  wire logic sample_en_i,
	input  wire logic pin_i,
	// Accepted edges, one cycle each
	output logic      rise_o,
	output logic      fall_o
);
	logic meta_r;
	logic sync_r;
	logic samp_r;
	logic level_r;
	logic agree;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
		end
	end

	assign agree = sample_en_i && (sync_r == samp_r);

	// Level accepted only when two successive samples agree
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			samp_r  <= 1'b0;
			level_r <= 1'b0;
			rise_o  <= 1'b0;
			fall_o  <= 1'b0;
		end else begin
			rise_o <= agree && sync_r && !level_r;
			fall_o <= agree && !sync_r && level_r;
			if (sample_en_i) begin
				samp_r <= sync_r;
			end
			if (agree) begin
				level_r <= sync_r;
			end
		end
	end
endmodule

// ---- timer0_capture.sv ----
// 16-bit capture/compare timer with event counting and square-wave output, AXI4-Lite slave
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module timer0_capture #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        SRST_I,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	// AXI4-Lite write response
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	// AXI4-Lite read
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	// External pins
	input  wire logic        EXT_IN0_I,
	input  wire logic        EXT_IN1_I,
	output logic             TIMER_OUT_O,
	// Interrupt requests, one cycle each
	output logic             MATCH_IRQ_A_O,
	output logic             CAPTURE_IRQ_B_O
);
	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
		$error("CNT_W must lie between 2 and 32");
	end

	logic [CNT_W-1:0]                main_counter_r;
	logic [CNT_W-1:0]                compare_capture_a_r;
	logic [CNT_W-1:0]                compare_capture_b_r;
	logic [7:0]                      prescaler_mode_reg_r;
	timer0_pkg::run_mode_t           mode_control_reg_r;
	logic [2:0]                      capcomp_control_reg_r;
	logic [1:0]                      output_control_reg_r;
	logic                            flag_a_r;
	logic                            capture_irq_flag_b_r;
	logic [timer0_pkg::PRESC_W-1:0]  presc_r;

	timer0_pkg::clk_sel_t            cks;
	timer0_pkg::edge_sel_t           es0;
	timer0_pkg::edge_sel_t           es1;
	logic                            running;
	logic                            ext_clk;
	logic                            div4;
	logic                            div8;
	logic                            div64;
	logic                            presc_tick;
	logic                            samp0_en;
	logic                            rise0;
	logic                            fall0;
	logic                            rise1;
	logic                            fall1;
	logic                            trig0;
	logic                            trig1;
	logic                            single0;
	logic                            count_en;
	logic                            restart;
	logic                            cap_b;
	logic                            cap_a_inv;
	logic                            cap_a_in1;
	logic                            match;
	logic                            set_a;
	logic                            wr_en;
	logic [7:0]                      wr_off;
	logic [7:0]                      rd_off;
	logic [31:0]                     rd_data;

	// Edge select decode shared by both inputs
	function automatic logic edge_hit(timer0_pkg::edge_sel_t es, logic r, logic f);
		unique case (es)
			timer0_pkg::EDGE_FALL: edge_hit = f;
			timer0_pkg::EDGE_RISE: edge_hit = r;
			timer0_pkg::EDGE_BOTH: edge_hit = r | f;
			timer0_pkg::EDGE_BAD:  edge_hit = 1'b0;
		endcase
	endfunction

	// Edge opposite to the selected one; none when both are selected
	function automatic logic opp_hit(timer0_pkg::edge_sel_t es, logic r, logic f);
		unique case (es)
			timer0_pkg::EDGE_FALL: opp_hit = r;
			timer0_pkg::EDGE_RISE: opp_hit = f;
			timer0_pkg::EDGE_BOTH: opp_hit = 1'b0;
			timer0_pkg::EDGE_BAD:  opp_hit = 1'b0;
		endcase
	endfunction

	function automatic logic is_mapped(logic [7:0] off);
		is_mapped = off <= timer0_pkg::OFF_FLAGS;
	endfunction

	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = nw[8*i +: 8];
			end
		end
	endfunction

	assign cks     = timer0_pkg::clk_sel_t'(prescaler_mode_reg_r[timer0_pkg::PRM_CKS_LSB +: 2]);
	assign es0     = timer0_pkg::edge_sel_t'(prescaler_mode_reg_r[timer0_pkg::PRM_ES0_LSB +: 2]);
	assign es1     = timer0_pkg::edge_sel_t'(prescaler_mode_reg_r[timer0_pkg::PRM_ES1_LSB +: 2]);
	assign running = mode_control_reg_r != timer0_pkg::MODE_STOP;
	assign ext_clk = cks == timer0_pkg::CKS_EXT;
	assign div4    = (presc_r & timer0_pkg::DIV4_MASK) == timer0_pkg::DIV4_MASK;
	assign div8    = (presc_r & timer0_pkg::DIV8_MASK) == timer0_pkg::DIV8_MASK;
	assign div64   = presc_r == timer0_pkg::DIV64_MASK;

	// Count clock and sampling strobe selection
	always_comb begin
		unique case (cks)
			timer0_pkg::CKS_FULL:  presc_tick = 1'b1;
			timer0_pkg::CKS_DIV4:  presc_tick = div4;
			timer0_pkg::CKS_DIV64: presc_tick = div64;
			timer0_pkg::CKS_EXT:   presc_tick = div8;
		endcase
	end

	assign samp0_en = ext_clk ? div8 : presc_tick;

	// Prescaler runs regardless of the timer so a start lands mid-period
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			presc_r <= '0;
		end else begin
			presc_r <= presc_r + 1'b1;
		end
	end

	edge_filter u_filt0 (
		.clk_i       (CLK_I),
		.srst_i      (SRST_I),
		.sample_en_i (samp0_en),
		.pin_i       (EXT_IN0_I),
		.rise_o      (rise0),
		.fall_o      (fall0)
	);

	edge_filter u_filt1 (
		.clk_i       (CLK_I),
		.srst_i      (SRST_I),
		.sample_en_i (presc_tick),
		.pin_i       (EXT_IN1_I),
		.rise_o      (rise1),
		.fall_o      (fall1)
	);

	// Stopped timer ignores its inputs
	assign trig0   = running && edge_hit(es0, rise0, fall0);
	assign trig1   = running && edge_hit(es1, rise1, fall1);
	assign single0 = es0 == timer0_pkg::EDGE_FALL || es0 == timer0_pkg::EDGE_RISE;
	assign count_en = running && (ext_clk ? trig0 : presc_tick);
	assign restart = mode_control_reg_r == timer0_pkg::MODE_RESTART && !ext_clk
		&& single0 && trig0;
	// In0 cannot trigger a capture while it is the count clock
	assign cap_b = capcomp_control_reg_r[timer0_pkg::CRC_B_CAP] && !ext_clk && trig0
		&& (mode_control_reg_r != timer0_pkg::MODE_RESTART || single0);
	assign cap_a_inv = running && !ext_clk && capcomp_control_reg_r[timer0_pkg::CRC_A_CAP]
		&& capcomp_control_reg_r[timer0_pkg::CRC_A_INV]
		&& opp_hit(es0, rise0, fall0);
	assign cap_a_in1 = capcomp_control_reg_r[timer0_pkg::CRC_A_CAP]
		&& !capcomp_control_reg_r[timer0_pkg::CRC_A_INV] && trig1;
	// Equality only, so a lowered compare value lets the counter wrap
	assign match = count_en && !capcomp_control_reg_r[timer0_pkg::CRC_A_CAP]
		&& main_counter_r == compare_capture_a_r;
	assign set_a = match || cap_a_in1;

	always_ff @(posedge CLK_I) begin
		if (SRST_I || !running || restart) begin
			main_counter_r <= '0;
		end else if (count_en) begin
			if (match && mode_control_reg_r == timer0_pkg::MODE_CLEAR_MATCH) begin
				main_counter_r <= '0;
			end else begin
				main_counter_r <= main_counter_r + 1'b1;
			end
		end
	end

	assign wr_en  = AWREADY_O;
	assign wr_off = {AWADDR_I[7:2], 2'b00};
	assign rd_off = {ARADDR_I[7:2], 2'b00};

	// Capture takes priority over a software write
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			compare_capture_a_r <= '0;
		end else if (cap_a_inv || cap_a_in1) begin
			compare_capture_a_r <= main_counter_r;
		end else if (wr_en && wr_off == timer0_pkg::OFF_CCA) begin
			compare_capture_a_r <= CNT_W'(merge(32'(compare_capture_a_r), WDATA_I, WSTRB_I));
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			compare_capture_b_r <= '0;
		end else if (cap_b) begin
			compare_capture_b_r <= main_counter_r;
		end else if (wr_en && wr_off == timer0_pkg::OFF_CCB) begin
			compare_capture_b_r <= CNT_W'(merge(32'(compare_capture_b_r), WDATA_I, WSTRB_I));
		end
	end

	// Control registers
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			prescaler_mode_reg_r  <= timer0_pkg::PRM_RST;
			mode_control_reg_r    <= timer0_pkg::MODE_STOP;
			capcomp_control_reg_r <= timer0_pkg::CRC_RST;
			output_control_reg_r  <= timer0_pkg::TOC_RST;
		end else if (wr_en && WSTRB_I[0]) begin
			unique case (wr_off)
				timer0_pkg::OFF_PRM:  prescaler_mode_reg_r <= WDATA_I[7:0];
				timer0_pkg::OFF_MODE:
					mode_control_reg_r <= timer0_pkg::run_mode_t'(WDATA_I[1:0]);
				timer0_pkg::OFF_CRC:  capcomp_control_reg_r <= WDATA_I[2:0];
				timer0_pkg::OFF_TOC:  output_control_reg_r <= WDATA_I[1:0];
				default: ;
			endcase
		end
	end

	// Requests, sticky flags (set wins over clear) and the output pin
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			MATCH_IRQ_A_O        <= 1'b0;
			CAPTURE_IRQ_B_O      <= 1'b0;
			flag_a_r             <= 1'b0;
			capture_irq_flag_b_r <= 1'b0;
		end else begin
			MATCH_IRQ_A_O   <= set_a;
			CAPTURE_IRQ_B_O <= cap_b;
			flag_a_r <= set_a || (flag_a_r && !(wr_en && wr_off == timer0_pkg::OFF_FLAGS
				&& WSTRB_I[0] && WDATA_I[timer0_pkg::FLAG_A]));
			capture_irq_flag_b_r <= cap_b || (capture_irq_flag_b_r && !(wr_en
				&& wr_off == timer0_pkg::OFF_FLAGS && WSTRB_I[0]
				&& WDATA_I[timer0_pkg::FLAG_B]));
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I || !output_control_reg_r[timer0_pkg::TOC_OE]) begin
			TIMER_OUT_O <= 1'b0;
		end else if (output_control_reg_r[timer0_pkg::TOC_TOGGLE] && match) begin
			TIMER_OUT_O <= !TIMER_OUT_O;
		end
	end

	// Write channel: take address and data together, answer one cycle later
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			AWREADY_O <= 1'b0;
			WREADY_O  <= 1'b0;
			BVALID_O  <= 1'b0;
			BRESP_O   <= timer0_pkg::RESP_OKAY;
		end else begin
			AWREADY_O <= AWVALID_I && WVALID_I && !AWREADY_O && !BVALID_O;
			WREADY_O  <= AWVALID_I && WVALID_I && !AWREADY_O && !BVALID_O;
			if (AWREADY_O) begin
				BVALID_O <= 1'b1;
				BRESP_O  <= is_mapped(wr_off) ? timer0_pkg::RESP_OKAY : timer0_pkg::RESP_SLVERR;
			end else if (BVALID_O && BREADY_I) begin
				BVALID_O <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (rd_off)
			timer0_pkg::OFF_COUNTER: rd_data = 32'(main_counter_r);
			timer0_pkg::OFF_CCA:     rd_data = 32'(compare_capture_a_r);
			timer0_pkg::OFF_CCB:     rd_data = 32'(compare_capture_b_r);
			timer0_pkg::OFF_PRM:     rd_data = 32'(prescaler_mode_reg_r);
			timer0_pkg::OFF_MODE:    rd_data = 32'(mode_control_reg_r);
			timer0_pkg::OFF_CRC:     rd_data = 32'(capcomp_control_reg_r);
			timer0_pkg::OFF_TOC:     rd_data = 32'(output_control_reg_r);
			timer0_pkg::OFF_FLAGS:   rd_data = 32'({capture_irq_flag_b_r, flag_a_r});
			default:                 rd_data = timer0_pkg::RD_ZERO;
		endcase
	end

	// Read channel
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ARREADY_O <= 1'b0;
			RVALID_O  <= 1'b0;
			RDATA_O   <= timer0_pkg::RD_ZERO;
			RRESP_O   <= timer0_pkg::RESP_OKAY;
		end else begin
			ARREADY_O <= ARVALID_I && !ARREADY_O && !RVALID_O;
			if (ARREADY_O) begin
				RVALID_O <= 1'b1;
				RDATA_O  <= rd_data;
				RRESP_O  <= is_mapped(rd_off) ? timer0_pkg::RESP_OKAY : timer0_pkg::RESP_SLVERR;
			end else if (RVALID_O && RREADY_I) begin
				RVALID_O <= 1'b0;
			end
		end
	end
endmodule

// ---- timer0_capture_sva.sv ----
// Port-level checker for the capture/compare timer
`timescale 1ns/1ps
module timer0_capture_sva #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic        CLK_I,
	input wire logic        SRST_I,
	// Register bus
	input wire logic [7:0]  AWADDR_I,
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic        WVALID_I,
	input wire logic [1:0]  BRESP_O,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	input wire logic        ARVALID_I,
	input wire logic [31:0] RDATA_O,
	input wire logic        RVALID_O,
	input wire logic        RREADY_I,
	// Pins and requests
	input wire logic        TIMER_OUT_O,
	input wire logic        MATCH_IRQ_A_O,
	input wire logic        CAPTURE_IRQ_B_O
);
	logic [7:0] prm_r;
	logic [1:0] mode_r;
	logic [1:0] toc_r;
	logic [4:0] quiet_r;
	logic       wr_hs;
	logic       settled;

	assign wr_hs   = AWREADY_O && AWVALID_I && WVALID_I;
	assign settled = quiet_r == 5'h1F;

	// Cycles since the last register write, so in-flight edges can drain
	always_ff @(posedge CLK_I) begin
		if (SRST_I || wr_hs)
			quiet_r <= 5'h00;
		else if (!settled)
			quiet_r <= quiet_r + 5'h01;
	end

	// Shadow of the control fields
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			prm_r  <= 8'h00;
			mode_r <= 2'h0;
			toc_r  <= 2'h0;
		end else if (wr_hs) begin
			if (AWADDR_I == timer0_pkg::OFF_PRM)
				prm_r <= WDATA_I[7:0];
			if (AWADDR_I == timer0_pkg::OFF_MODE)
				mode_r <= WDATA_I[1:0];
			if (AWADDR_I == timer0_pkg::OFF_TOC)
				toc_r <= WDATA_I[1:0];
		end
	end

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SRST_I);

	property p_out_off;
		!toc_r[timer0_pkg::TOC_OE] && settled |-> !TIMER_OUT_O;
	endproperty
	a_out_off: assert property (p_out_off) else $error("output pin high while disabled");

	property p_restart_edge;
		mode_r == timer0_pkg::MODE_RESTART && prm_r[5] && settled |-> !CAPTURE_IRQ_B_O;
	endproperty
	a_restart_edge: assert property (p_restart_edge) else $error("restart capture on bad edge");

	property p_bad_code;
		prm_r[5:4] == timer0_pkg::EDGE_BAD && settled |-> !CAPTURE_IRQ_B_O;
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("capture with prohibited edge");

	property p_ext_nocap;
		prm_r[1:0] == timer0_pkg::CKS_EXT && settled |-> !CAPTURE_IRQ_B_O;
	endproperty
	a_ext_nocap: assert property (p_ext_nocap) else $error("capture while counting edges");

	property p_irqb_pulse;
		CAPTURE_IRQ_B_O |=> !CAPTURE_IRQ_B_O;
	endproperty
	a_irqb_pulse: assert property (p_irqb_pulse) else $error("capture request too long");

	property p_stop_quiet;
		mode_r == timer0_pkg::MODE_STOP && settled |-> !CAPTURE_IRQ_B_O && !MATCH_IRQ_A_O;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("request while stopped");

	property p_wr_ans;
		wr_hs |=> BVALID_O;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write response late");

	property p_bhold;
		BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");

	property p_rd_ans;
		$rose(ARVALID_I) |-> ##2 RVALID_O;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read response late");

	property p_rhold;
		RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");

	c_cap_b: cover property (CAPTURE_IRQ_B_O);
	c_match_a: cover property (MATCH_IRQ_A_O);
	c_out_rise: cover property ($rose(TIMER_OUT_O));
endmodule

bind timer0_capture timer0_capture_sva #(.CNT_W(CNT_W)) timer0_capture_sva_i (
	.CLK_I, .SRST_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WVALID_I, .BRESP_O,
	.BVALID_O, .BREADY_I, .ARVALID_I, .RDATA_O, .RVALID_O, .RREADY_I, .TIMER_OUT_O,
	.MATCH_IRQ_A_O, .CAPTURE_IRQ_B_O
);

// ---- pulse_src.sv ----
// Far-side model: drives the timer input pins and times the output pin
`timescale 1ns/1ps
module pulse_src (
	input  wire logic clk_i,
	input  wire logic tout_i,
	output logic      in0_o,
	output logic      in1_o
);
	initial begin
		in0_o = 1'b0;
		in1_o = 1'b0;
	end

	// Pin zero high for hi cycles, then low for lo cycles
	task automatic pulse(input int hi, input int lo);
		@(posedge clk_i) in0_o <= 1'b1;
		repeat (hi) @(posedge clk_i);
		in0_o <= 1'b0;
		repeat (lo) @(posedge clk_i);
	endtask

	// Cycles between two successive output toggles
	task automatic gap(output int n);
		logic v;
		n = 0;
		@(posedge clk_i);
		v = tout_i;
		while (tout_i === v) @(posedge clk_i);
		v = tout_i;
		do begin
			@(posedge clk_i);
			n++;
		end while (tout_i === v);
	endtask
endmodule

// ---- test_timer0_capture.sv ----
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module test_timer0_capture;
	logic        CLK_I     = 1'b0;
	logic        SRST_I    = 1'b1;
	logic [7:0]  AWADDR_I  = 8'h00;
	logic        AWVALID_I = 1'b0;
	logic        AWREADY_O;
	logic [31:0] WDATA_I   = 32'h0000_0000;
	logic [3:0]  WSTRB_I   = 4'hF;
	logic        WVALID_I  = 1'b0;
	logic        WREADY_O;
	logic [1:0]  BRESP_O;
	logic        BVALID_O;
	logic        BREADY_I  = 1'b0;
	logic [7:0]  ARADDR_I  = 8'h00;
	logic        ARVALID_I = 1'b0;
	logic        ARREADY_O;
	logic [31:0] RDATA_O;
	logic [1:0]  RRESP_O;
	logic        RVALID_O;
	logic        RREADY_I  = 1'b0;
	logic        EXT_IN0_I;
	logic        EXT_IN1_I;
	logic        TIMER_OUT_O;
	logic        MATCH_IRQ_A_O;
	logic        CAPTURE_IRQ_B_O;
	int          fails;
	int          total_checks;
	int          irq_a_n;
	int          irq_b_n;
	int          base;
	int          n;
	logic [31:0] rd;
	logic [31:0] b;
	logic [1:0]  rs;

	timer0_capture timer0_capture_i (
		.CLK_I, .SRST_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WSTRB_I, .WVALID_I,
		.WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O,
		.RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .EXT_IN0_I, .EXT_IN1_I, .TIMER_OUT_O,
		.MATCH_IRQ_A_O, .CAPTURE_IRQ_B_O
	);
	pulse_src pulse_src_i (.clk_i(CLK_I), .tout_i(TIMER_OUT_O), .in0_o(EXT_IN0_I),
		.in1_o(EXT_IN1_I));

	always #20 CLK_I = ~CLK_I;

	always @(posedge CLK_I) begin
		if (MATCH_IRQ_A_O === 1'b1)
			irq_a_n++;
		if (CAPTURE_IRQ_B_O === 1'b1)
			irq_b_n++;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		AWADDR_I  <= a;
		WDATA_I   <= d;
		AWVALID_I <= 1'b1;
		WVALID_I  <= 1'b1;
		while (!(aw && w)) begin
			@(posedge CLK_I);
			if (AWREADY_O === 1'b1 && !aw) begin
				aw = 1'b1;
				AWVALID_I <= 1'b0;
			end
			if (WREADY_O === 1'b1 && !w) begin
				w = 1'b1;
				WVALID_I <= 1'b0;
			end
		end
		while (BVALID_O !== 1'b1) @(posedge CLK_I);
		// Response is made to wait one cycle so the hold checks see a stall
		BREADY_I <= 1'b1;
		@(posedge CLK_I);
		rs = BRESP_O;
		BREADY_I <= 1'b0;
		@(posedge CLK_I);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		ARADDR_I  <= a;
		ARVALID_I <= 1'b1;
		do @(posedge CLK_I); while (ARREADY_O !== 1'b1);
		ARVALID_I <= 1'b0;
		while (RVALID_O !== 1'b1) @(posedge CLK_I);
		RREADY_I <= 1'b1;
		@(posedge CLK_I);
		rd = RDATA_O;
		rs = RRESP_O;
		RREADY_I <= 1'b0;
		@(posedge CLK_I);
	endtask

	// Stop first, then program and restart with nonzero compare values
	task automatic setup(input logic [1:0] mode, input logic [7:0] prm, input logic [2:0] crc,
			input logic [31:0] a);
		axi_wr(timer0_pkg::OFF_MODE, 32'h0000_0000);
		axi_wr(timer0_pkg::OFF_PRM, 32'(prm));
		axi_wr(timer0_pkg::OFF_CRC, 32'(crc));
		axi_wr(timer0_pkg::OFF_CCA, a);
		axi_wr(timer0_pkg::OFF_CCB, a);
		axi_wr(timer0_pkg::OFF_MODE, 32'(mode));
	endtask

	initial begin
		repeat (20000) @(posedge CLK_I);
		fails++;
		wrap_up();
	end

	initial begin
		repeat (10) @(posedge CLK_I);
		SRST_I <= 1'b0;
		@(posedge CLK_I);
		for (int i = 0; i < 8; i++) begin
			axi_rd(8'(i * 4));
			chk("reset value", timer0_pkg::RD_ZERO, rd);
		end
		axi_wr(8'h20, 32'h0000_1234);
		chk("unmapped write", 32'(timer0_pkg::RESP_SLVERR), 32'(rs));
		axi_rd(8'h20);
		chk("unmapped read", 32'(timer0_pkg::RESP_SLVERR), 32'(rs));
		axi_wr(timer0_pkg::OFF_COUNTER, 32'h0000_1234);
		axi_rd(timer0_pkg::OFF_COUNTER);
		chk("counter read only", timer0_pkg::RD_ZERO, rd);
		// Every edge code in two-capture mode
		for (int e = 0; e < 4; e++) begin
			setup(timer0_pkg::MODE_FREE, 8'(e << 4), 3'h7, 32'h0000_5A5A);
			axi_wr(timer0_pkg::OFF_FLAGS, 32'h0000_0003);
			base = irq_b_n;
			pulse_src_i.pulse(20, 40);
			chk("capture count", (e == 2) ? 0 : (e == 3) ? 2 : 1, 32'(irq_b_n - base));
			axi_rd(timer0_pkg::OFF_FLAGS);
			chk("flag b", 32'(e != 2), 32'(rd[timer0_pkg::FLAG_B]));
			axi_rd(timer0_pkg::OFF_CCB);
			b = rd;
			axi_rd(timer0_pkg::OFF_CCA);
			if (e < 2)
				chk("pulse width", 32'h0000_0014, 32'(16'(e[0] ? rd - b : b - rd)));
			else
				chk("capture a", 32'h0000_5A5A, rd);
		end
		// Short pulse rejected at the divided sampling rate
		setup(timer0_pkg::MODE_FREE, 8'h11, 3'h4, 32'h0000_5A5A);
		base = irq_b_n;
		pulse_src_i.pulse(3, 40);
		chk("short pulse", 32'h0000_0000, 32'(irq_b_n - base));
		pulse_src_i.pulse(12, 60);
		chk("long pulse", 32'h0000_0001, 32'(irq_b_n - base));
		// Capture while B is being read
		setup(timer0_pkg::MODE_FREE, 8'h10, 3'h4, 32'h0000_5A5A);
		base = irq_b_n;
		fork
			pulse_src_i.pulse(20, 20);
			repeat (8) axi_rd(timer0_pkg::OFF_CCB);
		join
		chk("capture during read", 32'h0000_0001, 32'(irq_b_n - base));
		// Restart measurement
		setup(timer0_pkg::MODE_RESTART, 8'h10, 3'h4, 32'h0000_5A5A);
		repeat (2) pulse_src_i.pulse(10, 39);
		axi_rd(timer0_pkg::OFF_CCB);
		chk("restart period", 32'h0000_0031, rd);
		setup(timer0_pkg::MODE_RESTART, 8'h30, 3'h4, 32'h0000_5A5A);
		base = irq_b_n;
		pulse_src_i.pulse(10, 39);
		chk("restart both edges", 32'h0000_0000, 32'(irq_b_n - base));
		// Event counting with compare clear
		setup(timer0_pkg::MODE_CLEAR_MATCH, 8'h13, 3'h0, 32'h0000_0005);
		repeat (3) pulse_src_i.pulse(24, 24);
		axi_rd(timer0_pkg::OFF_COUNTER);
		chk("event count", 32'h0000_0003, rd);
		base = irq_a_n;
		repeat (3) pulse_src_i.pulse(24, 24);
		axi_rd(timer0_pkg::OFF_COUNTER);
		chk("event clear", 32'h0000_0000, rd);
		chk("match count", 32'h0000_0001, 32'(irq_a_n - base));
		pulse_src_i.pulse(6, 40);
		axi_rd(timer0_pkg::OFF_COUNTER);
		chk("event noise", 32'h0000_0000, rd);
		setup(timer0_pkg::MODE_CLEAR_MATCH, 8'h33, 3'h0, 32'h0000_0005);
		repeat (2) pulse_src_i.pulse(24, 24);
		axi_rd(timer0_pkg::OFF_COUNTER);
		chk("both edge count", 32'h0000_0004, rd);
		// Square wave, then compare lowered below the count
		setup(timer0_pkg::MODE_CLEAR_MATCH, 8'h00, 3'h0, 32'h0000_0009);
		axi_wr(timer0_pkg::OFF_TOC, 32'h0000_0003);
		pulse_src_i.gap(n);
		chk("toggle gap", 32'h0000_000A, 32'(n));
		axi_wr(timer0_pkg::OFF_CCA, 32'h0000_0100);
		repeat (200) @(posedge CLK_I);
		base = irq_a_n;
		axi_wr(timer0_pkg::OFF_CCA, 32'h0000_0010);
		axi_rd(timer0_pkg::OFF_COUNTER);
		chk("count past compare", 32'h0000_0001, 32'(rd[15:0] > 16'h0010));
		chk("no early match", 32'h0000_0000, 32'(irq_a_n - base));
		axi_wr(timer0_pkg::OFF_TOC, 32'h0000_0002);
		repeat (2) @(posedge CLK_I);
		chk("output off", 32'h0000_0000, 32'(TIMER_OUT_O));
		wrap_up();
	end
endmodule
